// file: core/ubti_top.sv
// Operation
// - Standard baud is clock/(16*(divisor+1))
// - High-speed baud is clock/(4*(divisor+1))
// - Divisor write clears the baud timer
// - Transmit enable raises irq two cycles later
// - 8-bit write loads shifter, starts without waiting for a tick
// - Enable after load starts output at once
// - 9-bit mode accepts only writes that select both low bytes
// - Break then sync: dummy, then 55h
// - Break is start, twelve zeros, stop
// - Reading receive data advances FIFO with flags
// - Infrared modes only in standard baud mode
// - Pin use 11 outputs the baud tick clock: 16x in standard, 4x in high-speed
// - Infrared enable encodes transmit, decodes receive
// - Module enable gives pins, else released
// - Idle-stop halts module during idle
// - RTS mode bit: simplex or flow control
// - Pin use field picks the driven pins
// - Wake on falling edge, clear on rise
// - Auto-baud measures 55h, then self-clears
// - Receive inversion makes low the idle level
// - Parity/data field selects frame format
// - Stop-count bit selects one or two
// - Loopback bit selects diagnostic mode
// - Ticks per bit: 4 high-speed, 16 standard
`include "ubti_cfg.svh"
module ubti_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Power states
  input wire logic idle_mode,
  input wire logic sleep_mode,
  // Serial pins
  input wire logic serial_in_pin,
  input wire logic clear_to_send_pin_n,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic request_to_send_pin_n,
  output logic request_to_send_oe,
  // Events
  output logic tx_irq,
  output logic rx_irq,
  output logic wake_irq
);
  // ----------------------------------------
  // Reset release and bus
  // ----------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  ubti_pkg::ubti_mode_t mode_ff;
  ubti_pkg::ubti_rx_entry_t head;
  ubti_pkg::ubti_tx_state_t tx_st_ff;
  ubti_pkg::ubti_rx_state_t rx_st_ff;
  logic ack_ff, wr_ev, rd_ev, acc;
  logic [31:0] dat_ff;
  logic [15:0] div_ff, cnt_ff, ab_div;
  logic brk_ff, txen_ff, receive_overrun_flag_ff, te_q1_ff, te_q2_ff, hold_v_ff;
  logic [2:0] rx_cnt;
  logic run, tick, nine, par_en, ir_on, brg_wr, te_rise, ab_load;
  logic [3:0] osr_last;

  assign acc = wb_cyc_i && wb_stb_i;
  assign wr_ev = acc && ack_ff && wb_we_i;
  assign rd_ev = acc && ack_ff && !wb_we_i;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign run = mode_ff.en && !(mode_ff.idle_stop && idle_mode);
  assign nine = mode_ff.pdsel == `UBTI_PD_NINE;
  assign par_en = mode_ff.pdsel == `UBTI_PD_EVEN || mode_ff.pdsel == `UBTI_PD_ODD;
  assign ir_on = mode_ff.infrared_codec_enable && !mode_ff.high_speed_baud_select;
  assign osr_last = mode_ff.high_speed_baud_select ? `UBTI_OSR_HS_LAST : `UBTI_OSR_STD_LAST;
  assign brg_wr = wr_ev && wb_adr_i == `UBTI_ADR_BRG;
  assign te_rise = txen_ff && !te_q1_ff;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end
    else
    begin
      ack_ff <= acc && !ack_ff;
      if (acc && !ack_ff)
      begin
        case (wb_adr_i)
          `UBTI_ADR_MODE: dat_ff <= {16'h0, mode_ff};
          `UBTI_ADR_STAT: dat_ff <= {20'h0, brk_ff, txen_ff, hold_v_ff,
            tx_st_ff == ubti_pkg::TX_IDLE && !hold_v_ff, 3'h0,
            rx_st_ff == ubti_pkg::RX_IDLE, head.parity_error_flag, head.framing_error_flag, receive_overrun_flag_ff, rx_cnt != 3'h0};
          `UBTI_ADR_RXD: dat_ff <= {23'h0, head.data};
          `UBTI_ADR_BRG: dat_ff <= {16'h0, div_ff};
          default: dat_ff <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic ab_done, wake_clr, brk_done, rx_push, flush;
  logic [15:0] mode_wmask;
  assign mode_wmask = `UBTI_MODE_WMASK;
  assign flush = wr_ev && wb_adr_i == `UBTI_ADR_STAT && wb_sel_i[0] && receive_overrun_flag_ff
    && !wb_dat_i[`UBTI_STA_RECEIVE_OVERRUN_FLAG];
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_ff <= `UBTI_MODE_RST;
    else
    begin
      if (wr_ev && wb_adr_i == `UBTI_ADR_MODE)
      begin
        if (wb_sel_i[0])
          mode_ff[7:0] <= wb_dat_i[7:0] & mode_wmask[7:0];
        if (wb_sel_i[1])
          mode_ff[15:8] <= wb_dat_i[15:8] & mode_wmask[15:8];
      end
      if (ab_done)
        mode_ff.auto_baud_enable_bit <= 1'b0;
      if (wake_clr)
        mode_ff.wake <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      brk_ff <= 1'b0;
      txen_ff <= 1'b0;
      receive_overrun_flag_ff <= 1'b0;
    end
    else
    begin
      if (wr_ev && wb_adr_i == `UBTI_ADR_STAT && wb_sel_i[1])
      begin
        brk_ff <= wb_dat_i[`UBTI_STA_BRK];
        txen_ff <= wb_dat_i[`UBTI_STA_TXEN];
      end
      if (brk_done)
        brk_ff <= 1'b0;
      if (flush)
        receive_overrun_flag_ff <= 1'b0;
      if (rx_push && rx_cnt == `UBTI_FIFO_DEPTH)
        receive_overrun_flag_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Baud timer
  // ----------------------------------------
  // Counter runs from 0 up to the divisor, so one tick every divisor+1 clocks
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_ff <= `UBTI_BRG_RST;
    else if (brg_wr)
    begin
      if (wb_sel_i[0])
        div_ff[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        div_ff[15:8] <= wb_dat_i[15:8];
    end
    else if (ab_load)
      div_ff <= ab_div;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= 16'h0;
    else if (!run || brg_wr || ab_load || te_rise || cnt_ff == div_ff)
      cnt_ff <= 16'h0;
    else
      cnt_ff <= cnt_ff + 16'h1;
  end
  assign tick = run && cnt_ff == div_ff;

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  logic [8:0] hold_ff, tsr_ff;
  logic tx_load, tx_wr, cts_ok, tx_end, brk_frm_ff, par_ff, stop2_ff, tx_bit;
  logic [3:0] tx_sub_ff, tx_n_ff;
  logic tx_irq_ff, tx_bit_ff;
  logic [1:0] pin_st_ff;
  assign cts_ok = mode_ff.pin_use != `UBTI_PIN_CTS || !pin_st_ff[1];
  assign tx_wr = wr_ev && wb_adr_i == `UBTI_ADR_TXD && wb_sel_i[0]
    && (!nine || wb_sel_i[1]);
  assign tx_load = tx_st_ff == ubti_pkg::TX_IDLE && hold_v_ff && txen_ff && run && cts_ok;
  assign tx_end = tick && tx_sub_ff == osr_last;
  assign brk_done = tx_st_ff == ubti_pkg::TX_STOP && tx_end && brk_frm_ff;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_ff <= 9'h0;
      hold_v_ff <= 1'b0;
    end
    else
    begin
      if (tx_load)
        hold_v_ff <= 1'b0;
      if (tx_wr && (!hold_v_ff || tx_load))
      begin
        hold_ff <= {nine & wb_dat_i[8], wb_dat_i[7:0]};
        hold_v_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_st_ff <= ubti_pkg::TX_IDLE;
      tx_sub_ff <= 4'h0;
      tx_n_ff <= 4'h0;
      tsr_ff <= 9'h0;
      brk_frm_ff <= 1'b0;
      par_ff <= 1'b0;
      stop2_ff <= 1'b0;
    end
    else if (!txen_ff || !run)
      tx_st_ff <= ubti_pkg::TX_IDLE;
    else
    begin
      if (tx_load)
        tx_sub_ff <= 4'h0;
      else if (tick)
        tx_sub_ff <= tx_sub_ff == osr_last ? 4'h0 : tx_sub_ff + 4'h1;
      case (tx_st_ff)
        ubti_pkg::TX_IDLE:
          if (tx_load)
          begin
            tx_st_ff <= ubti_pkg::TX_START;
            tsr_ff <= hold_ff;
            brk_frm_ff <= brk_ff;
            par_ff <= (mode_ff.pdsel == `UBTI_PD_ODD) ^ (^hold_ff[7:0]);
          end
        ubti_pkg::TX_START:
          if (tx_end)
          begin
            tx_st_ff <= ubti_pkg::TX_DATA;
            tx_n_ff <= 4'h0;
          end
        ubti_pkg::TX_DATA:
          if (tx_end)
          begin
            tsr_ff <= {1'b0, tsr_ff[8:1]};
            tx_n_ff <= tx_n_ff + 4'h1;
            if (tx_n_ff == (brk_frm_ff ? `UBTI_BRK_LAST : nine ? `UBTI_D9_LAST : `UBTI_D8_LAST))
            begin
              tx_st_ff <= par_en && !brk_frm_ff ? ubti_pkg::TX_PAR : ubti_pkg::TX_STOP;
              stop2_ff <= mode_ff.stop_count_select && !brk_frm_ff;
            end
          end
        ubti_pkg::TX_PAR:
          if (tx_end)
          begin
            tx_st_ff <= ubti_pkg::TX_STOP;
          end
        ubti_pkg::TX_STOP:
          if (tx_end)
          begin
            stop2_ff <= 1'b0;
            if (!stop2_ff)
              tx_st_ff <= ubti_pkg::TX_IDLE;
          end
        default: tx_st_ff <= ubti_pkg::TX_IDLE;
      endcase
    end
  end

  always_comb
  begin
    case (tx_st_ff)
      ubti_pkg::TX_START: tx_bit = 1'b0;
      ubti_pkg::TX_DATA: tx_bit = !brk_frm_ff && tsr_ff[0];
      ubti_pkg::TX_PAR: tx_bit = par_ff;
      default: tx_bit = 1'b1;
    endcase
  end

  // Infrared pulse is the first ticks of each zero bit
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_bit_ff <= 1'b1;
      te_q1_ff <= 1'b0;
      te_q2_ff <= 1'b0;
      tx_irq_ff <= 1'b0;
    end
    else
    begin
      tx_bit_ff <= ir_on ? !tx_bit && tx_sub_ff <= `UBTI_IR_PULSE : tx_bit;
      te_q1_ff <= txen_ff;
      te_q2_ff <= te_rise;
      tx_irq_ff <= te_q2_ff || tx_load;
    end
  end
  assign tx_irq = tx_irq_ff;

  // ----------------------------------------
  // Pin synchronisers and pin ownership
  // ----------------------------------------
  logic [1:0] s1_ff, s2_ff, s3_ff;
  logic bclk_ff;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff <= 2'b11;
      s2_ff <= 2'b11;
      s3_ff <= 2'b11;
      pin_st_ff <= 2'b11;
      bclk_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= {clear_to_send_pin_n, serial_in_pin};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_st_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (pin_st_ff & (s2_ff ^ s3_ff));
      bclk_ff <= run && cnt_ff > {1'b0, div_ff[15:1]};
    end
  end

  // Pins not selected stay with the port latches
  assign serial_out_oe = mode_ff.en && txen_ff;
  assign serial_out_pin = tx_bit_ff;
  assign request_to_send_oe = mode_ff.en && mode_ff.pin_use != 2'h0;
  always_comb
  begin
    if (mode_ff.pin_use == `UBTI_PIN_BCLK)
      request_to_send_pin_n = bclk_ff;
    else if (mode_ff.rts_pin_mode_bit)
      request_to_send_pin_n = tx_st_ff == ubti_pkg::TX_IDLE && !hold_v_ff;
    else
      request_to_send_pin_n = rx_cnt == `UBTI_FIFO_DEPTH;
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  logic lin, ir_dec, rx_in, rx_prev_ff, lin_prev_ff, mid, rpar_ff, wk_seen_ff;
  logic [3:0] ir_cnt_ff, rx_sub_ff, rx_n_ff;
  logic [8:0] rsr_ff, rdata;
  logic [2:0] ab_edges_ff;
  logic [23:0] ab_cnt_ff;
  ubti_pkg::ubti_rx_entry_t entry;
  assign lin = pin_st_ff[0] ^ mode_ff.receive_polarity_invert;
  assign ir_dec = lin && ir_cnt_ff == 4'h0;
  assign rx_in = mode_ff.loopback_select_bit ? tx_bit_ff : ir_on ? ir_dec : lin;
  assign mid = tick && rx_sub_ff == {1'b0, osr_last[3:1]};
  assign rdata = nine ? rsr_ff : {1'b0, rsr_ff[8:1]};
  assign entry.data = rdata;
  assign entry.framing_error_flag = !rx_in;
  assign entry.parity_error_flag = par_en && (rpar_ff ^ (mode_ff.pdsel == `UBTI_PD_ODD) ^ (^rdata[7:0]));
  assign rx_push = rx_st_ff == ubti_pkg::RX_STOP && mid;

  // Stretch each received pulse to a full bit of ticks
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ir_cnt_ff <= 4'h0;
    else if (!lin)
      ir_cnt_ff <= osr_last;
    else if (tick && ir_cnt_ff != 4'h0)
      ir_cnt_ff <= ir_cnt_ff - 4'h1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_ff <= ubti_pkg::RX_IDLE;
      rx_prev_ff <= 1'b1;
      rx_sub_ff <= 4'h0;
      rx_n_ff <= 4'h0;
      rsr_ff <= 9'h0;
      rpar_ff <= 1'b0;
    end
    else
    begin
      rx_prev_ff <= rx_in;
      rx_sub_ff <= rx_st_ff == ubti_pkg::RX_IDLE ? 4'h0 :
        tick ? (rx_sub_ff == osr_last ? 4'h0 : rx_sub_ff + 4'h1) : rx_sub_ff;
      case (rx_st_ff)
        ubti_pkg::RX_IDLE:
          if (run && !mode_ff.auto_baud_enable_bit && rx_prev_ff && !rx_in && !flush)
            rx_st_ff <= ubti_pkg::RX_START;
        ubti_pkg::RX_START:
          if (mid)
          begin
            rx_st_ff <= rx_in ? ubti_pkg::RX_IDLE : ubti_pkg::RX_DATA;
            rx_n_ff <= 4'h0;
          end
        ubti_pkg::RX_DATA:
          if (mid)
          begin
            rsr_ff <= {rx_in, rsr_ff[8:1]};
            rx_n_ff <= rx_n_ff + 4'h1;
            if (rx_n_ff == (nine ? `UBTI_D9_LAST : `UBTI_D8_LAST))
              rx_st_ff <= par_en ? ubti_pkg::RX_PAR : ubti_pkg::RX_STOP;
          end
        ubti_pkg::RX_PAR:
          if (mid)
          begin
            rpar_ff <= rx_in;
            rx_st_ff <= ubti_pkg::RX_STOP;
          end
        ubti_pkg::RX_STOP:
          if (mid)
            rx_st_ff <= ubti_pkg::RX_IDLE;
        default: rx_st_ff <= ubti_pkg::RX_IDLE;
      endcase
      if (!run || flush)
        rx_st_ff <= ubti_pkg::RX_IDLE;
    end
  end

  ubti_rx_mem u_rx_mem (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .flush(flush),
    .push(rx_push),
    .push_data(entry),
    .pop(rd_ev && wb_adr_i == `UBTI_ADR_RXD),
    .head_ff(head),
    .count_ff(rx_cnt)
  );

  // ----------------------------------------
  // Wake and auto-baud
  // ----------------------------------------
  // Divisor = cycles over eight bits / (8 * ticks per bit) - 1
  assign ab_div = mode_ff.high_speed_baud_select ? ab_cnt_ff[20:5] - 16'h1 : ab_cnt_ff[22:7] - 16'h1;
  assign ab_load = mode_ff.auto_baud_enable_bit && run && lin_prev_ff && !lin && ab_edges_ff == `UBTI_AB_EDGES;
  assign ab_done = ab_load;
  assign wake_clr = mode_ff.wake && wk_seen_ff && !lin_prev_ff && lin;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lin_prev_ff <= 1'b1;
      ab_edges_ff <= 3'h0;
      ab_cnt_ff <= 24'h0;
      wk_seen_ff <= 1'b0;
      rx_irq <= 1'b0;
      wake_irq <= 1'b0;
    end
    else
    begin
      lin_prev_ff <= lin;
      rx_irq <= rx_push && rx_cnt != `UBTI_FIFO_DEPTH;
      wake_irq <= mode_ff.wake && sleep_mode && lin_prev_ff && !lin;
      if (mode_ff.wake && sleep_mode && lin_prev_ff && !lin)
        wk_seen_ff <= 1'b1;
      else if (wake_clr || !mode_ff.wake)
        wk_seen_ff <= 1'b0;
      if (!mode_ff.auto_baud_enable_bit || ab_load)
      begin
        ab_edges_ff <= 3'h0;
        ab_cnt_ff <= 24'h0;
      end
      else
      begin
        if (ab_edges_ff != 3'h0)
          ab_cnt_ff <= ab_cnt_ff + 24'h1;
        if (run && lin_prev_ff && !lin)
          ab_edges_ff <= ab_edges_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_txirq_delay: assert property ($rose(txen_ff) |-> ##2 tx_irq)
    else $error("transmit irq not two cycles after enable");
  a_brg_clear: assert property (brg_wr |=> cnt_ff == 16'h0)
    else $error("baud timer not cleared on divisor write");
  a_tick_rate: assert property (tick && !brg_wr && !ab_load |=> cnt_ff == 16'h0)
    else $error("baud timer not restarted after tick");
  a_break_clear: assert property (brk_done |=> !brk_ff && tx_st_ff == ubti_pkg::TX_IDLE)
    else $error("send break not cleared after break");
  a_start_low: assert property (tx_st_ff == ubti_pkg::TX_START && !ir_on |=> !tx_bit_ff)
    else $error("start bit not low");
  a_pins_off: assert property (!mode_ff.en |-> !serial_out_oe && !request_to_send_oe)
    else $error("pins driven while disabled");
  a_bclk_pin: assert property (mode_ff.en && mode_ff.pin_use == `UBTI_PIN_BCLK
    |-> request_to_send_oe && request_to_send_pin_n == bclk_ff)
    else $error("baud clock not on shared pin");
  a_loop_path: assert property (mode_ff.loopback_select_bit |-> rx_in == tx_bit_ff)
    else $error("loopback path broken");
  a_ir_hs: assert property (mode_ff.high_speed_baud_select |=> serial_out_pin == $past(tx_bit))
    else $error("infrared encoding active in high-speed mode");
  a_frame_err: assert property (rx_push && !flush && rx_cnt == 3'h0 && !rx_in |=> head.framing_error_flag)
    else $error("framing error not flagged");
  c_tx_frame: cover property (tx_st_ff == ubti_pkg::TX_STOP && tx_end);
  c_rx_push: cover property (rx_push);
  c_break: cover property (brk_done);
  c_auto_baud_enable_bit: cover property (ab_load);
endmodule : ubti_top

// file: core/ubti_cfg.svh
`ifndef UBTI_CFG_SVH
`define UBTI_CFG_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define UBTI_ADR_MODE 8'h00
`define UBTI_ADR_STAT 8'h04
`define UBTI_ADR_TXD 8'h08
`define UBTI_ADR_RXD 8'h0c
`define UBTI_ADR_BRG 8'h10
// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define UBTI_MODE_RST 16'h0000
`define UBTI_MODE_WMASK 16'hbbff
`define UBTI_BRG_RST 16'h0000
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define UBTI_STA_BRK 11
`define UBTI_STA_TXEN 10
`define UBTI_STA_RECEIVE_OVERRUN_FLAG 1
`define UBTI_PD_EVEN 2'h1
`define UBTI_PD_ODD 2'h2
`define UBTI_PD_NINE 2'h3
`define UBTI_PIN_RTS 2'h1
`define UBTI_PIN_CTS 2'h2
`define UBTI_PIN_BCLK 2'h3
// ----------------------------------------
// Timing counts in baud ticks and bits, auto-baud edge count, FIFO depth
// ----------------------------------------
`define UBTI_OSR_STD_LAST 4'hf
`define UBTI_OSR_HS_LAST 4'h3
`define UBTI_IR_PULSE 4'h3
`define UBTI_BRK_LAST 4'hb
`define UBTI_D8_LAST 4'h7
`define UBTI_D9_LAST 4'h8
`define UBTI_AB_EDGES 3'h4
`define UBTI_FIFO_DEPTH 3'h4
`endif

// file: core/ubti_pkg.sv
package ubti_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010, TX_PAR = 3'b011, TX_STOP = 3'b100
  } ubti_tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_PAR = 3'b011, RX_STOP = 3'b100
  } ubti_rx_state_t;
  typedef struct packed {
    logic en;
    logic rsv14;
    logic idle_stop;
    logic infrared_codec_enable;
    logic rts_pin_mode_bit;
    logic rsv10;
    logic [1:0] pin_use;
    logic wake;
    logic loopback_select_bit;
    logic auto_baud_enable_bit;
    logic receive_polarity_invert;
    logic high_speed_baud_select;
    logic [1:0] pdsel;
    logic stop_count_select;
  } ubti_mode_t;
  typedef struct packed {
    logic parity_error_flag;
    logic framing_error_flag;
    logic [8:0] data;
  } ubti_rx_entry_t;
endpackage : ubti_pkg

// file: core/ubti_rx_mem.sv
`include "ubti_cfg.svh"
module ubti_rx_mem (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Write and read side
  input wire logic flush,
  input wire logic push,
  input wire ubti_pkg::ubti_rx_entry_t push_data,
  input wire logic pop,
  // Head and fill
  output ubti_pkg::ubti_rx_entry_t head_ff,
  output logic [2:0] count_ff
);
  ubti_pkg::ubti_rx_entry_t mem_ff [4];
  logic [1:0] wr_ptr_ff;
  logic [1:0] rd_ptr_ff;
  logic [1:0] rd_next;
  logic do_push;
  logic do_pop;
  logic bypass;

  assign do_pop = pop && (count_ff != 3'h0);
  assign do_push = push && (count_ff != `UBTI_FIFO_DEPTH);
  assign rd_next = do_pop ? rd_ptr_ff + 2'h1 : rd_ptr_ff;
  // New entry lands at the head when nothing older stays in front of it
  assign bypass = do_push && (count_ff == (do_pop ? 3'h1 : 3'h0));

  always_ff @(posedge sys_clk)
  begin
    if (do_push)
      mem_ff[wr_ptr_ff] <= push_data;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= 2'h0;
      rd_ptr_ff <= 2'h0;
      count_ff <= 3'h0;
      head_ff <= '0;
    end
    else if (flush)
    begin
      wr_ptr_ff <= 2'h0;
      rd_ptr_ff <= 2'h0;
      count_ff <= 3'h0;
      head_ff <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_ff <= wr_ptr_ff + 2'h1;
      rd_ptr_ff <= rd_next;
      count_ff <= 3'(count_ff + {2'b0, do_push} - {2'b0, do_pop});
      head_ff <= bypass ? push_data : mem_ff[rd_next];
    end
  end
endmodule : ubti_rx_mem

// file: testbench/ubti_peer.sv
module ubti_peer #(
  parameter int BIT_CLK = 32
) (
  // Clock
  input wire logic sys_clk,
  // Serial lines seen from the far station
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stop_bit;
  // Line idles high between frames
  initial rx_line = 1'b1;
  task automatic send(input logic [7:0] d, input logic p);
    logic [10:0] f;
    f = {1'b1, p, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rx_line <= f[i];
      repeat (BIT_CLK) @(posedge sys_clk);
    end
  endtask : send
  // Mid-bit sampling tolerates the one-cycle output lag
  task automatic get(output logic [7:0] d);
    @(negedge tx_line);
    repeat (BIT_CLK / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CLK) @(posedge sys_clk);
      d[i] = tx_line;
    end
    repeat (BIT_CLK) @(posedge sys_clk);
    stop_bit = tx_line;
  endtask : get
endmodule : ubti_peer

// file: testbench/uart_baud_txrx_infrared_tb.sv
`include "ubti_cfg.svh"
module uart_baud_txrx_infrared_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Divisor 1 in standard mode: 32 clocks a bit
  localparam int BIT_CLK = 32;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack, sout, sin, sout_oe, rts_n, rts_oe, tx_irq, rx_irq;
  logic [3:0] sel = 4'h3;
  logic [3:0] bsel = 4'h3;
  int failures = 0;
  int tx_irqs = 0;
  int rx_irqs = 0;
  int check_count = 0;
  int cyc_count = 0;
  logic [7:0] b0, b1;
  logic s0;
  ubti_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .idle_mode(1'b0), .sleep_mode(1'b0), .serial_in_pin(sin),
    .clear_to_send_pin_n(1'b0), .serial_out_pin(sout), .serial_out_oe(sout_oe),
    .request_to_send_pin_n(rts_n), .request_to_send_oe(rts_oe), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .wake_irq());
  ubti_peer #(.BIT_CLK(BIT_CLK)) peer_u (.sys_clk(sys_clk), .tx_line(sout), .rx_line(sin));
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  // Hang guard well above the few thousand cycles needed
  always @(posedge sys_clk)
  begin
    cyc_count++;
    if (tx_irq === 1'b1)
      tx_irqs++;
    if (rx_irq === 1'b1)
      rx_irqs++;
    if (cyc_count == 20000)
    begin
      failures++;
      results();
    end
  end
  // ----------------------------------------
  // Wishbone master
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= bsel;
    @(posedge sys_clk);
    while (ack !== 1'b1)
    begin
      @(posedge sys_clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rd_chk
  // Holding register is one deep: a write while it is full is dropped
  task automatic wait_tx_empty();
    logic [31:0] q;
    q = 32'h0;
    while (q[8] !== 1'b1)
    begin
      bus(1'b0, `UBTI_ADR_STAT, 32'h0, q);
    end
  endtask : wait_tx_empty
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd_chk(`UBTI_ADR_MODE, 32'hffff, 32'h0);
    wr(8'h1c, 32'hffff);
    rd_chk(8'h1c, 32'hffffffff, 32'h0);
    wr(`UBTI_ADR_MODE, 32'h4400);
    rd_chk(`UBTI_ADR_MODE, 32'hffff, 32'h0);
  endtask : t_regs
  task automatic t_tx();
    wr(`UBTI_ADR_BRG, 32'h1);
    wr(`UBTI_ADR_MODE, 32'h8000);
    wr(`UBTI_ADR_STAT, 32'h0400);
    fork
      peer_u.get(b0);
      wr(`UBTI_ADR_TXD, 32'ha5);
    join
    chk(b0, 8'ha5);
    chk(peer_u.stop_bit, 1'b1);
    chk(sout_oe, 1'b1);
    chk(tx_irqs, 32'h2);
  endtask : t_tx
  task automatic t_break();
    wait_tx_empty();
    fork
      begin
        peer_u.get(b0);
        s0 = peer_u.stop_bit;
        peer_u.get(b1);
      end
      begin
        wr(`UBTI_ADR_STAT, 32'h0c00);
        wr(`UBTI_ADR_TXD, 32'hff);
        wr(`UBTI_ADR_TXD, 32'h55);
      end
    join
    chk({b0, s0}, 9'h0);
    chk(b1, 8'h55);
    rd_chk(`UBTI_ADR_STAT, 32'h0800, 32'h0);
  endtask : t_break
  task automatic t_rx();
    wr(`UBTI_ADR_MODE, 32'h8002);
    peer_u.send(8'h3c, 1'b1);
    peer_u.send(8'h01, 1'b1);
    repeat (BIT_CLK) @(posedge sys_clk);
    rd_chk(`UBTI_ADR_STAT, 32'h0f, 32'h09);
    rd_chk(`UBTI_ADR_RXD, 32'h1ff, 32'h3c);
    rd_chk(`UBTI_ADR_STAT, 32'h0f, 32'h01);
    rd_chk(`UBTI_ADR_RXD, 32'h1ff, 32'h01);
    rd_chk(`UBTI_ADR_STAT, 32'h01, 32'h00);
    chk(rx_irqs, 32'h2);
  endtask : t_rx
  // No parity: the parity slot is taken as stop, so a low one is a framing error
  task automatic t_ovr();
    wr(`UBTI_ADR_MODE, 32'h8100);
    peer_u.send(8'h11, 1'b0);
    repeat (4) peer_u.send(8'h22, 1'b1);
    rd_chk(`UBTI_ADR_STAT, 32'h0f, 32'h07);
    chk({rts_oe, rts_n}, 2'h3);
    rd_chk(`UBTI_ADR_RXD, 32'h1ff, 32'h11);
    rd_chk(`UBTI_ADR_STAT, 32'h06, 32'h02);
    wr(`UBTI_ADR_STAT, 32'h0400);
    rd_chk(`UBTI_ADR_STAT, 32'h03, 32'h00);
    chk({rts_oe, rts_n}, 2'h2);
  endtask : t_ovr
  // High-speed 9-bit loopback; a byte-only write must be refused
  task automatic t_nine();
    wr(`UBTI_ADR_MODE, 32'h804e);
    bsel = 4'h1;
    wr(`UBTI_ADR_TXD, 32'h0ff);
    bsel = 4'h3;
    wr(`UBTI_ADR_TXD, 32'h1a5);
    repeat (12 * BIT_CLK) @(posedge sys_clk);
    rd_chk(`UBTI_ADR_RXD, 32'h1ff, 32'h1a5);
    rd_chk(`UBTI_ADR_STAT, 32'h01, 32'h00);
  endtask : t_nine
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_tx();
    t_break();
    t_rx();
    t_ovr();
    t_nine();
    results();
  end
endmodule : uart_baud_txrx_infrared_tb
